/* File: include/ptcr_regs.vh */
// Purpose: Offsets, field positions, reset values for the PHY tuning bank
// Assumes: Registers are 16 bits, one aligned 32-bit APB word each
// Notes:   Offsets are register indices; byte address is index times four
`ifndef PTCR_REGS_VH
`define PTCR_REGS_VH

// ****************************************
// Register indices
// ****************************************
`define PTCR_IDX_SWING_CD      10'h0A3
`define PTCR_IDX_RX_LPF        10'h0B3
`define PTCR_IDX_RX_EQ_EN      10'h0C0
`define PTCR_IDX_CLKOUT        10'h0C6
`define PTCR_IDX_SYNC_BUF      10'h0E9
`define PTCR_IDX_LOOPBACK      10'h0FE
`define PTCR_IDX_SIGPROC       10'h100
`define PTCR_IDX_FFE           10'h12C
`define PTCR_IDX_SW_RESET      10'h01F

// ****************************************
// Field positions
// ****************************************
`define PTCR_CHD_EN_BIT        13
`define PTCR_CHD_VAL_HI        12
`define PTCR_CHD_VAL_LO        8
`define PTCR_CHC_EN_BIT        5
`define PTCR_CHC_VAL_HI        4
`define PTCR_CHC_VAL_LO        0
`define PTCR_CLK_SEL_BIT       4
`define PTCR_FFE_HI            9
`define PTCR_SWRST_BIT         14

// ****************************************
// Reset values
// ****************************************
`define PTCR_RST_SWING         5'h10
`define PTCR_RST_RX_LPF        16'h0000
`define PTCR_RST_RX_EQ_EN      16'h0000
`define PTCR_RST_SYNC_BUF      16'h9F22
`define PTCR_RST_LOOPBACK      16'h0001
`define PTCR_RST_SIGPROC       16'h051C
`define PTCR_RST_FFE_FIELD     10'h000
`define PTCR_FFE_RSVD          6'h03

`endif

/* File: hw/ptcr_rst_sync.v */
// Purpose: Two-flop release of the active-low reset
// Assumes: rst_b may assert at any time
// Notes:   Assert is asynchronous, release is synchronous
`timescale 1ns/1ps
`default_nettype none

module ptcr_rst_sync (
    // Clock and raw reset
    input  wire mclk,
    input  wire rst_b,
    // Synchronised reset
    output wire rst_sync_b
);

    reg meta_r;
    reg hold_r;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= 1'b0;
            hold_r <= 1'b0;
        end else begin
            meta_r <= 1'b1;
            hold_r <= meta_r;
        end
    end

    assign rst_sync_b = hold_r;

endmodule // ptcr_rst_sync

`default_nettype wire

/* File: hw/ptcr_regs.v */
// Purpose: APB register bank for line-driver, receiver and DSP tuning
// Assumes: 20 MHz mclk; APB master as per protocol; 16-bit registers
// Notes:   Zero wait states; unmapped addresses answer with pslverr
`include "ptcr_regs.vh"
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Channel D override drives stored swing value
// - Channel C override drives stored swing value
// - Clock select routes test clock out
// - Clock control reserved bits read zero
module ptcr_regs #(
    parameter ADDR_W = 12
) (
    // Clock and reset
    input  wire              mclk,
    input  wire              rst_b,
    // APB slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    input  wire [3:0]        pstrb,
    output reg  [31:0]       prdata,
    output wire              pready,
    output reg               pslverr,
    // Line-driver swing controls
    output reg               chd_swing_override_en,
    output reg  [4:0]        chd_swing_value,
    output reg               chc_swing_override_en,
    output reg  [4:0]        chc_swing_value,
    // Clock output path
    input  wire              pll_clock,
    input  wire              transmit_test_clock,
    output reg               clkout_test_select,
    output reg               clkout_sel_pll_b,
    // Tuning words to analog and DSP
    output reg  [15:0]       rx_lowpass_setting,
    output reg  [15:0]       rx_equalizer_enable_setting,
    output reg  [15:0]       sync_buffer_setting,
    output reg  [15:0]       loop_setup_value,
    output reg  [15:0]       signal_processor_setting,
    output reg  [9:0]        feedforward_eq_setting,
    // Loopback value pending a software reset
    output reg               loop_change_pending
);

    // ****************************************
    // Reset and bus decode
    // ****************************************
    wire rst_sync_b;

    ptcr_rst_sync u_rst (
        .mclk       (mclk),
        .rst_b      (rst_b),
        .rst_sync_b (rst_sync_b)
    );

    // Index of a word address; low two bits select bytes
    function [9:0] word_idx;
        input [ADDR_W-1:0] a;
        begin
            word_idx = a[11:2];
        end
    endfunction

    // Merge low two write lanes into a 16-bit register
    function [15:0] lane_merge;
        input [15:0] old;
        input [31:0] wd;
        input [3:0]  st;
        begin
            lane_merge[7:0]  = st[0] ? wd[7:0]  : old[7:0];
            lane_merge[15:8] = st[1] ? wd[15:8] : old[15:8];
        end
    endfunction

    wire [9:0] idx    = word_idx(paddr);
    wire       access = psel & penable;
    wire       wr_en  = access & pwrite;

    reg        hit;
    reg [15:0] rd_val;
    wire [15:0] swing_cd_word = {2'b00, chd_swing_override_en,
                                 chd_swing_value, 2'b00,
                                 chc_swing_override_en, chc_swing_value};

    // Zero-wait slave: every access completes in its first cycle
    assign pready = 1'b1;

    always @* begin
        hit    = 1'b1;
        rd_val = 16'h0000;
        case (idx)
            `PTCR_IDX_SWING_CD: rd_val = swing_cd_word;
            `PTCR_IDX_RX_LPF:   rd_val = rx_lowpass_setting;
            `PTCR_IDX_RX_EQ_EN: rd_val = rx_equalizer_enable_setting;
            `PTCR_IDX_CLKOUT:
                rd_val = {11'h000, clkout_test_select, 4'h0};
            `PTCR_IDX_SYNC_BUF: rd_val = sync_buffer_setting;
            `PTCR_IDX_LOOPBACK: rd_val = loop_setup_value;
            `PTCR_IDX_SIGPROC:  rd_val = signal_processor_setting;
            `PTCR_IDX_FFE:
                rd_val = {`PTCR_FFE_RSVD, feedforward_eq_setting};
            `PTCR_IDX_SW_RESET: rd_val = 16'h0000;
            default:            hit    = 1'b0;
        endcase
    end

    // ****************************************
    // Read data and error
    // ****************************************
    // Registered one edge early: setup cycle decodes, access cycle drives
    always @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel & ~penable) begin
            prdata  <= pwrite ? 32'h0000_0000 : {16'h0000, rd_val};
            pslverr <= ~hit;
        end else if (access) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // ****************************************
    // Writable registers
    // ****************************************
    wire [15:0] wr_swing  = lane_merge(swing_cd_word, pwdata, pstrb);
    wire [15:0] wr_clkout = lane_merge({11'h000, clkout_test_select,
                                        4'h0}, pwdata, pstrb);
    wire [15:0] wr_ffe    = lane_merge({`PTCR_FFE_RSVD,
                                        feedforward_eq_setting},
                                       pwdata, pstrb);
    wire        swrst_wr  = wr_en & (idx == `PTCR_IDX_SW_RESET) &
                            pstrb[1] & pwdata[`PTCR_SWRST_BIT];

    always @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            chd_swing_override_en       <= 1'b0;
            chd_swing_value             <= `PTCR_RST_SWING;
            chc_swing_override_en       <= 1'b0;
            chc_swing_value             <= `PTCR_RST_SWING;
            clkout_test_select          <= 1'b0;
            rx_lowpass_setting          <= `PTCR_RST_RX_LPF;
            rx_equalizer_enable_setting <= `PTCR_RST_RX_EQ_EN;
            sync_buffer_setting         <= `PTCR_RST_SYNC_BUF;
            loop_setup_value            <= `PTCR_RST_LOOPBACK;
            signal_processor_setting    <= `PTCR_RST_SIGPROC;
            feedforward_eq_setting      <= `PTCR_RST_FFE_FIELD;
            loop_change_pending         <= 1'b0;
        end else begin
            if (wr_en) begin
                case (idx)
                    `PTCR_IDX_SWING_CD: begin
                        chd_swing_override_en <=
                            wr_swing[`PTCR_CHD_EN_BIT];
                        chd_swing_value <=
                            wr_swing[`PTCR_CHD_VAL_HI:`PTCR_CHD_VAL_LO];
                        chc_swing_override_en <=
                            wr_swing[`PTCR_CHC_EN_BIT];
                        chc_swing_value <=
                            wr_swing[`PTCR_CHC_VAL_HI:`PTCR_CHC_VAL_LO];
                    end
                    `PTCR_IDX_CLKOUT:
                        clkout_test_select <=
                            wr_clkout[`PTCR_CLK_SEL_BIT];
                    `PTCR_IDX_RX_LPF:
                        rx_lowpass_setting <= lane_merge(
                            rx_lowpass_setting, pwdata, pstrb);
                    `PTCR_IDX_RX_EQ_EN:
                        rx_equalizer_enable_setting <= lane_merge(
                            rx_equalizer_enable_setting, pwdata,
                            pstrb);
                    `PTCR_IDX_SYNC_BUF:
                        sync_buffer_setting <= lane_merge(
                            sync_buffer_setting, pwdata, pstrb);
                    `PTCR_IDX_LOOPBACK:
                        loop_setup_value <= lane_merge(
                            loop_setup_value, pwdata, pstrb);
                    `PTCR_IDX_SIGPROC:
                        signal_processor_setting <= lane_merge(
                            signal_processor_setting, pwdata, pstrb);
                    `PTCR_IDX_FFE:
                        feedforward_eq_setting <=
                            wr_ffe[`PTCR_FFE_HI:0];
                    default: ;
                endcase
            end
            // New loopback value waits for a software reset; set wins
            if (wr_en && idx == `PTCR_IDX_LOOPBACK)
                loop_change_pending <= 1'b1;
            else if (swrst_wr)
                loop_change_pending <= 1'b0;
        end
    end

    // ****************************************
    // Clock output select
    // ****************************************
    // Select flop only; the actual clock mux is glitch-safe analog
    always @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b)
            clkout_sel_pll_b <= 1'b0;
        else
            clkout_sel_pll_b <= clkout_test_select;
    end

endmodule // ptcr_regs

`default_nettype wire

/* File: tb/ptcr_regs_properties.sv */
// Purpose: Port-level properties of the tuning register bank
// Assumes: Zero-wait APB slave, registers in the low half-word
// Notes:   Attached to every instance of the bank by bind
`timescale 1ns/1ps
`default_nettype none
module ptcr_regs_props #(
    parameter ADDR_W = 12
) (
    // Clock, reset and bus
    input wire logic              mclk, rst_b, psel, penable, pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata, prdata,
    input wire logic [3:0]        pstrb,
    // Swing and clock select
    input wire logic              chd_swing_override_en, clkout_test_select,
    input wire logic              chc_swing_override_en,
    input wire logic [4:0]        chd_swing_value, chc_swing_value
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire       wr = psel && penable && pwrite;
    wire       rd = psel && penable && !pwrite;
    wire [9:0] wi = paddr[11:2];
    a_chd_write_lands: assert property (
        wr && wi == 10'h0A3 && pstrb[1] |=> {chd_swing_override_en,
        chd_swing_value} == $past(pwdata[13:8]))
        else $error("channel D swing not taken from the write");
    a_chc_write_lands: assert property (
        wr && wi == 10'h0A3 && pstrb[0] |=> {chc_swing_override_en,
        chc_swing_value} == $past(pwdata[5:0]))
        else $error("channel C swing not taken from the write");
    a_swing_held: assert property (
        !(wr && wi == 10'h0A3) |=> $stable({chd_swing_override_en,
        chd_swing_value, chc_swing_override_en, chc_swing_value}))
        else $error("swing changed without a write");
    a_clk_sel_write: assert property (
        wr && wi == 10'h0C6 && pstrb[0]
        |=> clkout_test_select == $past(pwdata[4]))
        else $error("clock select not taken from the write");
    a_clk_sel_read: assert property (
        rd && wi == 10'h0C6 |-> prdata[4] == clkout_test_select)
        else $error("clock select reads back wrong");
    a_clk_rsvd_zero: assert property (
        rd && wi == 10'h0C6 |-> prdata[15:5] == 11'h000
        && prdata[3:0] == 4'h0)
        else $error("clock control reserved bits not zero");
    a_upper_half_zero: assert property (
        rd |-> prdata[31:16] == 16'h0000)
        else $error("read data above bit 15 not zero");
    a_ffe_rsvd_fixed: assert property (
        rd && wi == 10'h12C |-> prdata[15:10] == 6'h03)
        else $error("equalizer reserved bits changed");
    c_swing_write: cover property (wr && wi == 10'h0A3);
    c_clk_read: cover property (rd && wi == 10'h0C6);
    c_ffe_read: cover property (rd && wi == 10'h12C);
endmodule // ptcr_regs_props
bind ptcr_regs ptcr_regs_props #(.ADDR_W(ADDR_W)) i_ptcr_regs_props (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pstrb(pstrb), .clkout_test_select(clkout_test_select),
    .chd_swing_override_en(chd_swing_override_en),
    .chc_swing_override_en(chc_swing_override_en),
    .chd_swing_value(chd_swing_value), .chc_swing_value(chc_swing_value));
`default_nettype wire

/* File: tb/ptcr_regs_bench.sv */
// Purpose: Self-checking bench for the tuning register bank
// Assumes: Zero-wait slave; one idle cycle between transfers
// Notes:   Array m mirrors what each register should hold
`timescale 1ns/1ps
`default_nettype none
module ptcr_regs_bench;
    logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic        e, cde, cce, sel, pend, psb;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, rv;
    logic [3:0]  pstrb;
    logic [4:0]  cdv, ccv;
    logic [15:0] lpf, eqe, syn, lpv, dsp;
    logic [9:0]  ffe;
    logic [15:0] m [8];
    logic [9:0]  ix [8] = '{10'h0A3, 10'h0B3, 10'h0C0, 10'h0C6,
                            10'h0E9, 10'h0FE, 10'h100, 10'h12C};
    logic [15:0] msk [8] = '{16'h3F3F, 16'hFFFF, 16'hFFFF, 16'h0010,
                             16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h03FF};
    logic [15:0] rsv [8] = '{16'h1010, 16'h0000, 16'h0000, 16'h0000,
                             16'h9F22, 16'h0001, 16'h051C, 16'h0000};
    logic [15:0] cv [8] = '{16'hFFFF, 16'h000C, 16'h0000, 16'hFFFF,
                            16'h60DD, 16'h7390, 16'h1027, 16'h0E81};
    integer      seed = 87, fails = 0, compares = 0, cyc = 0, k;

    ptcr_regs i_ptcr_regs (.mclk(mclk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chd_swing_override_en(cde), .chd_swing_value(cdv),
        .chc_swing_override_en(cce), .chc_swing_value(ccv),
        .pll_clock(1'b0), .transmit_test_clock(1'b0),
        .clkout_test_select(sel), .clkout_sel_pll_b(psb),
        .rx_lowpass_setting(lpf), .rx_equalizer_enable_setting(eqe),
        .sync_buffer_setting(syn), .loop_setup_value(lpv),
        .signal_processor_setting(dsp), .feedforward_eq_setting(ffe),
        .loop_change_pending(pend));

    initial begin
        mclk = 0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails = fails + 1;
            wrap_up;
        end
    end

    task wrap_up;
        if (fails == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input [127:0] g, input [127:0] x);
        compares = compares + 1;
        if (g !== x) begin
            fails = fails + 1;
            $display("unexpected at %0t: %h not %h", $time, g, x);
        end
    endtask
    // Idle edge first, so strobes never change twice in one step
    task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
        @(posedge mclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task acc(input integer k, input [15:0] d, input [3:0] s);
        logic [15:0] lm;
        lm = {{8{s[1]}}, {8{s[0]}}};
        m[k] = (m[k] & ~lm) | (d & lm);
        apb(1, {ix[k], 2'b00}, {d, d}, s);
        apb(0, {ix[k], 2'b00}, 32'h0, 4'h0);
        chk({e, r}, {17'h0, (m[k] & msk[k]) | (k == 7 ? 16'h0C00 : 16'h0)});
        chk({cde, cdv, cce, ccv, sel, psb, lpf, eqe, syn, lpv, dsp, ffe},
            {m[0][13:8], m[0][5:0], m[3][4], m[3][4], m[1], m[2], m[4],
             m[5], m[6], m[7][9:0]});
    endtask
    // Write with no lanes must change nothing but pend, so it checks reset values
    task rst_chk;
        rst_b <= 0;
        repeat (6) @(posedge mclk);
        rst_b <= 1;
        repeat (3) @(posedge mclk);
        m = rsv;
        for (k = 0; k < 8; k++) acc(k, 16'hFFFF, 4'h0);
    endtask

    initial begin
        rst_b = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        pstrb = 0;
        rst_chk;
        for (k = 0; k < 8; k++) acc(k, cv[k], 4'hF);
        chk(pend, 1'b1);
        apb(1, 12'h07C, 32'h4000, 4'hF);
        // Read back lets the clear settle before pend is looked at
        apb(0, 12'h07C, 32'h0, 4'h0);
        chk({e, r}, {1'b0, 32'h0});
        chk(pend, 1'b0);
        apb(1, 12'hFFC, 32'hFFFF, 4'hF);
        apb(0, 12'hFFC, 32'h0, 4'h0);
        chk({e, r}, {1'b1, 32'h0});
        rst_chk;
        repeat (60) begin
            rv = $random(seed);
            // Loopback only ever takes its setup pattern, then a reset
            acc(rv[2:0], rv[2:0] == 3'd5 ? cv[5] : rv[31:16],
                rv[2:0] == 3'd5 ? 4'hF : rv[7:4]);
            if (rv[2:0] == 3'd5) apb(1, 12'h07C, 32'h4000, 4'hF);
        end
        wrap_up;
    end
endmodule // ptcr_regs_bench
`default_nettype wire
